//--- hdl/decode_rename_stall_event_select.sv
// Summary of operation
// - d1h/04h counts decoded stack-pointer instructions
// - stack ops update delta register, no uop
// - d1h/08h counts delta-to-pointer sync operations
// - d2h/01h counts flag-related stall cycles
// - flag stall: consumer needs flags left unmodified
// - d2h/02h counts partial-register stall cycles
// - d2h/04h counts read-port stall cycles
// - retried read-port stall cycle counted again
// - d2h/08h counts scoreboard serialization stall cycles
// - d2h/0fh counts flag, partial-register, read-port and status word stall cycles, not serialization
// - d4h/01h counts segment rename stall cycles
// - second update to pending segment stalls front end
module decode_rename_stall_event_select #(
  parameter int LANES = stall_event_pkg::LANES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // counter programming
  input stall_event_pkg::evt_sel_s i_evt_sel,
  // decode stage
  input stall_event_pkg::dec_lane_s [LANES-1:0] i_dec,
  input wire logic i_sync_req,
  // flag producer and consumer
  input stall_event_pkg::flag_op_s i_flag_wr,
  input stall_event_pkg::flag_op_s i_flag_rd,
  // register writer and reader
  input stall_event_pkg::reg_op_s i_reg_wr,
  input stall_event_pkg::reg_op_s i_reg_rd,
  // stall levels from the allocation stage
  input wire logic i_readport_stall,
  input wire logic i_serialize_stall,
  input wire logic i_fpu_status_word_stall,
  // segment rename and retire
  input stall_event_pkg::seg_op_s i_seg_update,
  input stall_event_pkg::seg_op_s i_seg_retire,
  // counter side
  output logic [stall_event_pkg::INC_W-1:0] o_count_inc,
  output logic o_sel_match,
  // stack pointer state
  output logic [stall_event_pkg::SP_W-1:0] o_stack_pointer,
  output logic [stall_event_pkg::OFS_W-1:0] o_stack_delta_register,
  // front end hold
  output logic o_frontend_stall
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************

  // the increment field must hold a full decode group
  if (LANES < 1 ||
      LANES >= (1 << stall_event_pkg::INC_W)) begin : g_lanes_chk
    $error("LANES out of range for increment width");
  end

  // sign extension of a lane delta needs a wider offset
  if (stall_event_pkg::OFS_W <= stall_event_pkg::DELTA_W) begin : g_ofs_chk
    $error("offset not wider than a lane delta");
  end

  // the offset is sign extended into the pointer on a sync
  if (stall_event_pkg::SP_W <= stall_event_pkg::OFS_W) begin : g_sp_chk
    $error("pointer not wider than the offset");
  end

  // every index must name exactly one tracked register or segment
  if (stall_event_pkg::NREGS !=
      (1 << stall_event_pkg::REG_IDX_W)) begin : g_reg_chk
    $error("register count does not match its index width");
  end
  if (stall_event_pkg::NSEGS !=
      (1 << stall_event_pkg::SEG_IDX_W)) begin : g_seg_chk
    $error("segment count does not match its index width");
  end

  // ***************************************************************
  // stack pointer folding
  // ***************************************************************

  logic [stall_event_pkg::SP_W-1:0] sp_d, sp_q;
  logic [stall_event_pkg::OFS_W-1:0] ofs_d, ofs_q;
  logic [stall_event_pkg::OFS_W-1:0] lane_sum;
  logic [stall_event_pkg::INC_W-1:0] fold_cnt;
  logic sync_evt;

  // sum the deltas of this cycle's stack ops, sign extended
  // invalid lanes and non-stack lanes add nothing
  function automatic logic [stall_event_pkg::OFS_W-1:0] delta_sum(
    input stall_event_pkg::dec_lane_s [LANES-1:0] d
  );
    logic [stall_event_pkg::OFS_W-1:0] s;
    s = stall_event_pkg::OFS_RESET;
    for (int i = 0; i < LANES; i++) begin
      if (d[i].valid && d[i].stack_op) begin
        s = s + {{(stall_event_pkg::OFS_W - stall_event_pkg::DELTA_W)
                 {d[i].delta[stall_event_pkg::DELTA_W-1]}}, d[i].delta};
      end
    end
    return s;
  endfunction

  // count the stack ops decoded in this group
  function automatic logic [stall_event_pkg::INC_W-1:0] fold_count(
    input stall_event_pkg::dec_lane_s [LANES-1:0] d
  );
    logic [stall_event_pkg::INC_W-1:0] c;
    c = stall_event_pkg::INC_ZERO;
    for (int i = 0; i < LANES; i++) begin
      if (d[i].valid && d[i].stack_op) begin
        c = c + 3'h1;
      end
    end
    return c;
  endfunction

  // fold deltas into the offset; a sync adds it to the pointer.
  // deltas decoded in the sync cycle start the fresh offset so none
  // is lost or applied twice
  // the offset wraps at its width; a long run of stack ops without a
  // sync loses the carry, which callers must keep within range
  always_comb begin
    lane_sum = delta_sum(i_dec);
    fold_cnt = fold_count(i_dec);
    sync_evt = i_sync_req;
    sp_d = sp_q;
    ofs_d = ofs_q + lane_sum;
    if (i_sync_req) begin
      sp_d = sp_q + {{(stall_event_pkg::SP_W - stall_event_pkg::OFS_W)
                     {ofs_q[stall_event_pkg::OFS_W-1]}}, ofs_q};
      ofs_d = lane_sum;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sp_q <= stall_event_pkg::SP_RESET;
      ofs_q <= stall_event_pkg::OFS_RESET;
    end else begin
      sp_q <= sp_d;
      ofs_q <= ofs_d;
    end
  end

  // ***************************************************************
  // partial flag tracking
  // ***************************************************************

  logic [stall_event_pkg::FLAG_W-1:0] fmask_d, fmask_q;
  logic fpart_d, fpart_q;
  logic flag_stall;

  // remember which flags the last producer wrote; a consumer that
  // needs any other flag waits for a merge. the check uses the old
  // mask, so a consumer in the producer's own cycle sees the prior one
  // only the latest producer is remembered, so an older partial write
  // hidden behind a full one never causes a stall
  always_comb begin
    flag_stall = i_flag_rd.valid && fpart_q &&
                 ((i_flag_rd.mask & ~fmask_q) != '0);
    fmask_d = fmask_q;
    fpart_d = fpart_q;
    if (i_flag_wr.valid) begin
      fmask_d = i_flag_wr.mask;
      fpart_d = (i_flag_wr.mask != stall_event_pkg::FLAG_ALL);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fmask_q <= stall_event_pkg::FLAG_ALL;
      fpart_q <= 1'b0;
    end else begin
      fmask_q <= fmask_d;
      fpart_q <= fpart_d;
    end
  end

  // ***************************************************************
  // partial register tracking
  // ***************************************************************

  logic [stall_event_pkg::NREGS-1:0] preg_d, preg_q;
  logic preg_stall;

  // a read of a partly written register costs extra latency; the
  // merge clears the mark, but a new partial write in the same cycle
  // to the same register wins over that clear
  // a read in the writer's own cycle sees the old mark, so its stall
  // shows on the next read of that register
  always_comb begin
    preg_stall = i_reg_rd.valid && preg_q[i_reg_rd.idx];
    preg_d = preg_q;
    if (preg_stall) begin
      preg_d[i_reg_rd.idx] = 1'b0;
    end
    if (i_reg_wr.valid) begin
      preg_d[i_reg_wr.idx] = i_reg_wr.partial;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      preg_q <= '0;
    end else begin
      preg_q <= preg_d;
    end
  end

  // ***************************************************************
  // segment rename resources
  // ***************************************************************

  logic [stall_event_pkg::NSEGS-1:0] seg_pend_d, seg_pend_q;
  logic seg_stall_d, seg_stall_q;
  logic [stall_event_pkg::SEG_IDX_W-1:0] seg_wait_d, seg_wait_q;
  logic retire_hit;

  // one rename in flight per segment. a second update to a pending
  // segment holds the front end; the held update is presented again
  // after release. a retire and a fresh rename of the same segment
  // in one cycle leave it pending
  // only one held update is remembered: further updates during a stall
  // are refused and the front end must present them again
  always_comb begin
    seg_pend_d = seg_pend_q;
    seg_stall_d = seg_stall_q;
    seg_wait_d = seg_wait_q;
    retire_hit = i_seg_retire.valid &&
                 (i_seg_retire.idx == i_seg_update.idx);
    if (i_seg_retire.valid) begin
      seg_pend_d[i_seg_retire.idx] = 1'b0;
    end
    if (seg_stall_q) begin
      if (i_seg_retire.valid && i_seg_retire.idx == seg_wait_q) begin
        seg_stall_d = 1'b0;
      end
    end else if (i_seg_update.valid) begin
      if (seg_pend_q[i_seg_update.idx] && !retire_hit) begin
        seg_stall_d = 1'b1;
        seg_wait_d = i_seg_update.idx;
      end else begin
        seg_pend_d[i_seg_update.idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      seg_pend_q <= '0;
      seg_stall_q <= 1'b0;
      seg_wait_q <= '0;
    end else begin
      seg_pend_q <= seg_pend_d;
      seg_stall_q <= seg_stall_d;
      seg_wait_q <= seg_wait_d;
    end
  end

  // ***************************************************************
  // condition bundle and selection
  // ***************************************************************

  stall_event_pkg::cond_s cond;

  // read-port stall is a level, so a retried cycle counts again; the
  // total leaves out scoreboard serialization, which is separate
  // the status word stall has no selection of its own and only feeds
  // the total
  always_comb begin
    cond.fold_cnt = fold_cnt;
    cond.sync = sync_evt;
    cond.flag = flag_stall;
    cond.preg = preg_stall;
    cond.readport = i_readport_stall;
    cond.serialize = i_serialize_stall;
    cond.total = i_readport_stall || preg_stall || flag_stall ||
                 i_fpu_status_word_stall;
    cond.seg = seg_stall_q;
  end

  // the selector registers the increment, so it lags its cause by one
  // cycle; the counter sees a clean flip-flop output
  event_select u_event_select (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sel(i_evt_sel),
    .i_cond(cond),
    .o_inc(o_count_inc),
    .o_match(o_sel_match)
  );

  // ***************************************************************
  // outputs
  // ***************************************************************

  // every output comes straight from a flip-flop
  assign o_stack_pointer = sp_q;
  assign o_stack_delta_register = ofs_q;
  assign o_frontend_stall = seg_stall_q;

endmodule // decode_rename_stall_event_select

//--- hdl/stall_event_pkg.sv
package stall_event_pkg;

  // ***************************************************************
  // event selection codes
  // ***************************************************************
  localparam logic [7:0] EVT_DECODED = 8'hd1;
  localparam logic [7:0] UM_STACK_FOLD = 8'h04;
  localparam logic [7:0] UM_STACK_SYNC = 8'h08;
  localparam logic [7:0] EVT_ALLOC_STALL = 8'hd2;
  localparam logic [7:0] UM_STALL_FLAG = 8'h01;
  localparam logic [7:0] UM_STALL_PREG = 8'h02;
  localparam logic [7:0] UM_STALL_READPORT = 8'h04;
  localparam logic [7:0] UM_STALL_SERIALIZE = 8'h08;
  localparam logic [7:0] UM_STALL_TOTAL = 8'h0f;
  localparam logic [7:0] EVT_SEG_ALIAS = 8'hd4;
  localparam logic [7:0] UM_SEG_ALIAS = 8'h01;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int LANES = 4;
  localparam int INC_W = 3;
  localparam int DELTA_W = 8;
  localparam int SP_W = 32;
  localparam int OFS_W = 16;
  localparam int FLAG_W = 6;
  localparam int NREGS = 16;
  localparam int REG_IDX_W = 4;
  localparam int NSEGS = 4;
  localparam int SEG_IDX_W = 2;
  localparam logic [SP_W-1:0] SP_RESET = 32'h0000_0000;
  localparam logic [OFS_W-1:0] OFS_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAG_ALL = 6'h3f;
  localparam logic [INC_W-1:0] INC_ZERO = 3'h0;

  // ***************************************************************
  // selected condition
  // ***************************************************************
  typedef enum logic [8:0] {
    SEL_NONE      = 9'h001,
    SEL_FOLD      = 9'h002,
    SEL_SYNC      = 9'h004,
    SEL_FLAG      = 9'h008,
    SEL_PREG      = 9'h010,
    SEL_READPORT  = 9'h020,
    SEL_SERIALIZE = 9'h040,
    SEL_TOTAL     = 9'h080,
    SEL_SEG       = 9'h100
  } sel_e;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] umask;
  } evt_sel_s;

  typedef struct packed {
    logic valid;
    logic stack_op;
    logic signed [DELTA_W-1:0] delta;
  } dec_lane_s;

  typedef struct packed {
    logic valid;
    logic [FLAG_W-1:0] mask;
  } flag_op_s;

  typedef struct packed {
    logic valid;
    logic partial;
    logic [REG_IDX_W-1:0] idx;
  } reg_op_s;

  typedef struct packed {
    logic valid;
    logic [SEG_IDX_W-1:0] idx;
  } seg_op_s;

  typedef struct packed {
    logic [INC_W-1:0] fold_cnt;
    logic sync;
    logic flag;
    logic preg;
    logic readport;
    logic serialize;
    logic total;
    logic seg;
  } cond_s;

  // map a programmed code and mask to a condition, none if unlisted
  function automatic sel_e sel_decode(input evt_sel_s s);
    sel_e r;
    r = SEL_NONE;
    if (s.code == EVT_DECODED && s.umask == UM_STACK_FOLD) r = SEL_FOLD;
    if (s.code == EVT_DECODED && s.umask == UM_STACK_SYNC) r = SEL_SYNC;
    if (s.code == EVT_ALLOC_STALL) begin
      case (s.umask)
        UM_STALL_FLAG: r = SEL_FLAG;
        UM_STALL_PREG: r = SEL_PREG;
        UM_STALL_READPORT: r = SEL_READPORT;
        UM_STALL_SERIALIZE: r = SEL_SERIALIZE;
        UM_STALL_TOTAL: r = SEL_TOTAL;
        default: r = SEL_NONE;
      endcase
    end
    if (s.code == EVT_SEG_ALIAS && s.umask == UM_SEG_ALIAS) r = SEL_SEG;
    return r;
  endfunction

endpackage

// ***************************************************************
// event multiplexer: one registered increment for the counter
// ***************************************************************
module event_select (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // selection and conditions
  input stall_event_pkg::evt_sel_s i_sel,
  input stall_event_pkg::cond_s i_cond,
  // counter side
  output logic [stall_event_pkg::INC_W-1:0] o_inc,
  output logic o_match
);

  stall_event_pkg::sel_e sel;
  logic [stall_event_pkg::INC_W-1:0] inc_d, inc_q;
  logic match_d, match_q;

  // pick the condition; unlisted selections pass nothing
  always_comb begin
    sel = stall_event_pkg::sel_decode(i_sel);
    match_d = (sel != stall_event_pkg::SEL_NONE);
    inc_d = stall_event_pkg::INC_ZERO;
    case (sel)
      stall_event_pkg::SEL_FOLD: inc_d = i_cond.fold_cnt;
      stall_event_pkg::SEL_SYNC: inc_d = {2'h0, i_cond.sync};
      stall_event_pkg::SEL_FLAG: inc_d = {2'h0, i_cond.flag};
      stall_event_pkg::SEL_PREG: inc_d = {2'h0, i_cond.preg};
      stall_event_pkg::SEL_READPORT: begin
        inc_d = {2'h0, i_cond.readport};
      end
      stall_event_pkg::SEL_SERIALIZE: begin
        inc_d = {2'h0, i_cond.serialize};
      end
      stall_event_pkg::SEL_TOTAL: inc_d = {2'h0, i_cond.total};
      stall_event_pkg::SEL_SEG: inc_d = {2'h0, i_cond.seg};
      default: inc_d = stall_event_pkg::INC_ZERO;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      inc_q <= stall_event_pkg::INC_ZERO;
      match_q <= 1'b0;
    end else begin
      inc_q <= inc_d;
      match_q <= match_d;
    end
  end

  assign o_inc = inc_q;
  assign o_match = match_q;

endmodule // event_select

//--- verif/stall_event_properties.sv
// ***************************************************************
// port checker for the stall event selector
// ***************************************************************
module stall_event_checker #(
  parameter int LANES = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input stall_event_pkg::evt_sel_s i_evt_sel,
  input stall_event_pkg::dec_lane_s [LANES-1:0] i_dec,
  input wire logic i_sync_req,
  input wire logic i_readport_stall,
  input wire logic i_serialize_stall,
  input wire logic i_fpu_status_word_stall,
  input stall_event_pkg::seg_op_s i_seg_retire,
  input wire logic [stall_event_pkg::INC_W-1:0] o_count_inc,
  input wire logic o_sel_match,
  input wire logic [stall_event_pkg::SP_W-1:0] o_stack_pointer,
  input wire logic [stall_event_pkg::OFS_W-1:0] o_stack_delta_register,
  input wire logic o_frontend_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sel;
  logic listed;
  logic [stall_event_pkg::INC_W-1:0] fold_n;

  // selection key and stack lanes this cycle
  assign sel = i_evt_sel;
  always_comb begin
    listed = sel inside {16'hd104, 16'hd108, 16'hd201, 16'hd202,
                         16'hd204, 16'hd208, 16'hd20f, 16'hd401};
    fold_n = '0;
    for (int i = 0; i < LANES; i++) begin
      fold_n = fold_n + 3'(i_dec[i].valid & i_dec[i].stack_op);
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  unlisted_quiet_a: assert property (
    !listed |=> !o_sel_match && o_count_inc == 3'h0)
    else $error("increment passed for an unlisted selection");
  listed_match_a: assert property (
    listed |=> o_sel_match) else $error("listed selection not matched");
  fold_count_a: assert property (
    sel == 16'hd104 |=> o_count_inc == $past(fold_n))
    else $error("stack fold increment wrong");
  sync_count_a: assert property (
    sel == 16'hd108 |=> o_count_inc == {2'h0, $past(i_sync_req)})
    else $error("sync increment wrong");
  readport_count_a: assert property (
    sel == 16'hd204 |=> o_count_inc == {2'h0, $past(i_readport_stall)})
    else $error("read port increment wrong");
  readport_again_a: assert property (
    (sel == 16'hd204 && i_readport_stall) [*2] |=>
    o_count_inc == 3'h1 && $past(o_count_inc) == 3'h1)
    else $error("persisting read port stall not counted again");
  serialize_count_a: assert property (
    sel == 16'hd208 |=> o_count_inc == {2'h0, $past(i_serialize_stall)})
    else $error("serialize increment wrong");
  total_count_a: assert property (
    sel == 16'hd20f && (i_readport_stall || i_fpu_status_word_stall)
    |=> o_count_inc == 3'h1) else $error("total stall not counted");
  seg_count_a: assert property (
    sel == 16'hd401 |=> o_count_inc == {2'h0, $past(o_frontend_stall)})
    else $error("segment stall increment wrong");
  stall_hold_a: assert property (
    o_frontend_stall && !i_seg_retire.valid |=> o_frontend_stall)
    else $error("front end stall dropped without retire");
  sync_apply_a: assert property (
    i_sync_req |=> o_stack_pointer == $past(o_stack_pointer) +
    {{16{$past(o_stack_delta_register[15])}}, $past(o_stack_delta_register)})
    else $error("sync did not fold delta into pointer");

  // main scenarios reached
  cover property ((sel == 16'hd204 && i_readport_stall) [*2]);
  cover property ($rose(o_frontend_stall));
  cover property (sel == 16'hd108 && i_sync_req);
endmodule // stall_event_checker

bind decode_rename_stall_event_select stall_event_checker #(
  .LANES(LANES)) checker_i (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_evt_sel(i_evt_sel), .i_dec(i_dec), .i_sync_req(i_sync_req),
  .i_readport_stall(i_readport_stall),
  .i_serialize_stall(i_serialize_stall),
  .i_fpu_status_word_stall(i_fpu_status_word_stall),
  .i_seg_retire(i_seg_retire), .o_count_inc(o_count_inc),
  .o_sel_match(o_sel_match), .o_stack_pointer(o_stack_pointer),
  .o_stack_delta_register(o_stack_delta_register),
  .o_frontend_stall(o_frontend_stall));

//--- verif/tb.sv
// ***************************************************************
// self-checking bench with a cycle model
// ***************************************************************
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 4;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  stall_event_pkg::evt_sel_s i_evt_sel = '0;
  stall_event_pkg::dec_lane_s [LANES-1:0] i_dec = '0;
  logic i_sync_req = 1'b0;
  stall_event_pkg::flag_op_s i_flag_wr = '0;
  stall_event_pkg::flag_op_s i_flag_rd = '0;
  stall_event_pkg::reg_op_s i_reg_wr = '0;
  stall_event_pkg::reg_op_s i_reg_rd = '0;
  logic i_readport_stall = 1'b0;
  logic i_serialize_stall = 1'b0;
  logic i_fpu_status_word_stall = 1'b0;
  stall_event_pkg::seg_op_s i_seg_update = '0;
  stall_event_pkg::seg_op_s i_seg_retire = '0;
  logic [stall_event_pkg::INC_W-1:0] o_count_inc;
  logic o_sel_match;
  logic [31:0] o_stack_pointer;
  logic [15:0] o_stack_delta_register;
  logic o_frontend_stall;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 39;
  int cyc = 0;
  int m_inc;
  int m_match;
  logic [31:0] m_sp;
  logic [15:0] m_ofs;
  logic [15:0] m_mark;
  logic [5:0] m_fmask;
  logic [3:0] m_pend;
  logic [1:0] m_wait;
  logic m_stall;
  logic [15:0] sels [11] = '{16'hd104, 16'hd108, 16'hd201, 16'hd202,
    16'hd204, 16'hd208, 16'hd20f, 16'hd401, 16'hd203, 16'hd10f, 16'hd501};

  always #10 i_mclk = ~i_mclk;

  decode_rename_stall_event_select #(.LANES(LANES))
    decode_rename_stall_event_select_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_evt_sel(i_evt_sel), .i_dec(i_dec), .i_sync_req(i_sync_req),
    .i_flag_wr(i_flag_wr), .i_flag_rd(i_flag_rd), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_readport_stall(i_readport_stall),
    .i_serialize_stall(i_serialize_stall),
    .i_fpu_status_word_stall(i_fpu_status_word_stall),
    .i_seg_update(i_seg_update), .i_seg_retire(i_seg_retire),
    .o_count_inc(o_count_inc), .o_sel_match(o_sel_match),
    .o_stack_pointer(o_stack_pointer),
    .o_stack_delta_register(o_stack_delta_register),
    .o_frontend_stall(o_frontend_stall));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one clock edge of the reference model, inputs as sampled
  task automatic model_step();
    int f;
    logic fl;
    logic pr;
    logic [15:0] sum;
    f = 0;
    sum = 16'h0;
    for (int i = 0; i < LANES; i++) begin
      if (i_dec[i].valid && i_dec[i].stack_op) begin
        f++;
        sum += {{8{i_dec[i].delta[7]}}, i_dec[i].delta};
      end
    end
    fl = i_flag_rd.valid && ((i_flag_rd.mask & ~m_fmask) != 6'h0);
    pr = i_reg_rd.valid && m_mark[i_reg_rd.idx];
    m_match = 1;
    case (i_evt_sel)
      16'hd104: m_inc = f;
      16'hd108: m_inc = i_sync_req;
      16'hd201: m_inc = fl;
      16'hd202: m_inc = pr;
      16'hd204: m_inc = i_readport_stall;
      16'hd208: m_inc = i_serialize_stall;
      16'hd20f: m_inc = i_readport_stall | pr | fl | i_fpu_status_word_stall;
      16'hd401: m_inc = m_stall;
      default: begin
        m_inc = 0;
        m_match = 0;
      end
    endcase
    if (pr) m_mark[i_reg_rd.idx] = 1'b0;
    if (i_reg_wr.valid) m_mark[i_reg_wr.idx] = i_reg_wr.partial;
    if (i_flag_wr.valid) m_fmask = i_flag_wr.mask;
    if (i_sync_req) begin
      m_sp += {{16{m_ofs[15]}}, m_ofs};
      m_ofs = sum;
    end else begin
      m_ofs += sum;
    end
    if (m_stall) begin
      if (i_seg_retire.valid && i_seg_retire.idx == m_wait) m_stall = 1'b0;
      if (i_seg_retire.valid) m_pend[i_seg_retire.idx] = 1'b0;
    end else begin
      if (i_seg_retire.valid) m_pend[i_seg_retire.idx] = 1'b0;
      if (i_seg_update.valid && m_pend[i_seg_update.idx]) begin
        m_stall = 1'b1;
        m_wait = i_seg_update.idx;
      end else if (i_seg_update.valid) begin
        m_pend[i_seg_update.idx] = 1'b1;
      end
    end
    if (i_rst) begin
      {m_inc, m_match, m_sp, m_ofs, m_mark, m_pend, m_stall} = '0;
      m_fmask = 6'h3f;
    end
  endtask

  // random traffic; small register and segment index ranges force hits
  task automatic drive();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    for (int i = 0; i < LANES; i++) begin
      i_dec[i] = {a[i], a[i+4], b[8*i +: 8]};
    end
    i_sync_req = a[8];
    i_flag_wr = {a[9], a[15:10]};
    i_flag_rd = {a[16], a[22:17]};
    i_reg_wr = {a[23], a[24], 2'h0, a[26:25]};
    i_reg_rd = {a[27], c[11], 2'h0, a[29:28]};
    i_readport_stall = a[30];
    i_serialize_stall = a[31];
    i_fpu_status_word_stall = c[9] & c[10];
    i_seg_update = {c[0] & c[1], c[3:2]};
    i_seg_retire = {c[4] & c[5] & c[6], c[8:7]};
  endtask

  // model and compare every edge, with a hang limit
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      final_report();
    end else begin
      model_step();
      #1;
      check("count_inc", m_inc, o_count_inc);
      check("sel_match", m_match, o_sel_match);
      check("stack_pointer", m_sp, o_stack_pointer);
      check("stack_delta", m_ofs, o_stack_delta_register);
      check("frontend_stall", m_stall, o_frontend_stall);
    end
  end

  // sweep listed and unlisted selections, one reset in mid-run
  initial begin
    repeat (6) @(posedge i_mclk);
    #1;
    for (int k = 0; k < 11; k++) begin
      i_evt_sel = sels[k];
      for (int n = 0; n < 60; n++) begin
        i_rst = (k == 5 && n < 2);
        drive();
        @(posedge i_mclk);
        #1;
      end
    end
    final_report();
  end
endmodule // tb
